// ### core/sync_output_stage.sv
`timescale 1ns/1ps
module sync_output_stage (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [sync_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [sync_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [sync_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [sync_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic pixel_output_clock,
	input wire logic line_sync_in,
	input wire logic green_embedded_sync,
	input wire logic frame_sync_in,
	input wire logic separated_frame_sync,
	input wire logic regen_line_sync,
	input wire logic filtered_line_sync,
	input wire logic frame_sync_pin_in,
	output logic line_sync_out,
	output logic frame_sync_out,
	output logic frame_sync_oe,
	output logic slicer_select_out,
	output logic field_odd,
	output logic address_strap_bit
);
	import sync_pkg::*;

	// ==========================================
	// Helpers
	function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
		reg_index = a[ADDR_W-1:2];
	endfunction

	function automatic logic drive_level(input logic active, input logic active_high);
		drive_level = active ? active_high : ~active_high;
	endfunction

	function automatic logic known_index(input logic [7:0] i);
		known_index = (i == IDX_VS_CTRL) || (i == IDX_VS_DUR) || (i == IDX_OUT_CTRL) ||
			(i == IDX_HS_WIDTH) || (i == IDX_STATUS) || (i == IDX_SLICER);
	endfunction

	// ==========================================
	// Input synchronisers
	pins_s pins;
	pins_s p_lvl;
	pins_s p_rise;
	pins_s p_fall;

	assign pins.vs_pin = frame_sync_pin_in;
	assign pins.pix_clk = pixel_output_clock;
	assign pins.filt_line = filtered_line_sync;
	assign pins.regen_line = regen_line_sync;
	assign pins.sep_frame = separated_frame_sync;
	assign pins.frame = frame_sync_in;
	assign pins.line = line_sync_in;
	assign pins.green = green_embedded_sync;

	edge_sync #(
		.W(PINS_W)
	) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.d(pins),
		.lvl(p_lvl),
		.rise(p_rise),
		.fall(p_fall)
	);

	// ==========================================
	// State
	state_s s;
	state_s n;

	logic [7:0] wr_idx;
	logic [7:0] rd_idx;
	logic vs_force;
	logic vs_active_low;
	logic vs_in_act;
	logic vs_edge;
	logic pass_act;
	logic pass_edge;
	logic sel_act;
	logic sel_edge;
	logic frame_act;
	logic line_start;
	logic hs_act;
	logic [DATA_W-1:0] rd_val;

	always_comb begin
		n = s;
		wr_idx = reg_index(s.aw_addr);
		rd_idx = reg_index(s_axi_araddr);

		// ==========================================
		// Start-up strap capture
		if (s.phase == PH_STRAP) begin
			if (s.strap_cnt == 8'(STRAP_CYC)) begin
				n.addr_strap = p_lvl.vs_pin; // [R11]
				n.phase = PH_RUN;
			end else begin
				n.strap_cnt = s.strap_cnt + 8'h01;
			end
		end

		// ==========================================
		// Frame sync input sense
		vs_force = s.vs_ctrl[VS_POL_FORCE_BIT];
		if (p_lvl.frame) begin
			if (s.pol_acc != POL_ACC_MAX) begin
				n.pol_acc = s.pol_acc + 16'h0001;
			end
		end else begin
			if (s.pol_acc != ~POL_ACC_MAX) begin
				n.pol_acc = s.pol_acc - 16'h0001;
			end
		end
		if (vs_force) begin
			vs_active_low = ~s.vs_ctrl[VS_POL_LEVEL_BIT]; // [R12]
		end else begin
			vs_active_low = ~s.pol_acc[CNT_W-1] && (s.pol_acc != '0); // [R12]
		end
		vs_in_act = p_lvl.frame ^ vs_active_low;

		// ==========================================
		// Line sync regeneration on pixel clock
		line_start = 1'b0;
		if (p_rise.line) begin
			n.hs_pend = 1'b1;
		end
		if (p_rise.pix_clk) begin
			if (s.hs_pend || p_rise.line) begin
				n.hs_pend = 1'b0;
				n.hs_cnt = s.hs_width; // [R1] [R2]
				n.line_len = s.hcount;
				n.hcount = '0;
				line_start = 1'b1;
			end else begin
				n.hcount = s.hcount + 16'h0001;
				if (s.hs_cnt != 8'h00) begin
					n.hs_cnt = s.hs_cnt - 8'h01; // [R3]
				end
			end
		end
		hs_act = (n.hs_cnt != 8'h00);
		if (p_rise.pix_clk) begin
			n.line_out = drive_level(hs_act, s.out_ctrl[OUT_HS_POL_BIT]); // [R2] [R3]
		end

		// ==========================================
		// Frame sync output
		pass_act = vs_in_act;
		vs_edge = pass_act && !s.vs_prev;
		pass_edge = vs_edge;
		n.vs_prev = pass_act;
		sel_act = s.out_ctrl[OUT_VS_PASS_BIT] ? pass_act : p_lvl.sep_frame; // [R4]
		sel_edge = s.out_ctrl[OUT_VS_PASS_BIT] ? pass_edge : p_rise.sep_frame; // [R4]
		if (sel_edge) begin
			n.vs_cnt = s.vs_dur; // [R6]
		end else if (line_start && (s.vs_cnt != 8'h00)) begin
			n.vs_cnt = s.vs_cnt - 8'h01; // [R6]
		end
		if (s.vs_ctrl[VS_DUR_EN_BIT]) begin
			frame_act = sel_edge || (s.vs_cnt != 8'h00); // [R6]
		end else begin
			frame_act = sel_act; // [R6]
		end
		n.frame_out = drive_level(frame_act, s.out_ctrl[OUT_VS_POL_BIT]); // [R5] [R7]

		// ==========================================
		// Odd and even field
		if (pass_edge) begin
			n.field_odd = (s.hcount >= (s.line_len >> 1)); // [R10] [R13]
		end

		// ==========================================
		// Slicer output
		case (s.slicer)
			SL_GREEN_RAW: n.slicer_out = p_lvl.green; // [R8] [R9]
			SL_LINE_RAW: n.slicer_out = p_lvl.line; // [R8]
			SL_LINE_REGEN: n.slicer_out = p_lvl.regen_line; // [R8]
			SL_LINE_FILT: n.slicer_out = p_lvl.filt_line; // [R8]
			default: n.slicer_out = 1'b0;
		endcase

		// ==========================================
		// Register write
		if (s_axi_awvalid && !s.aw_full) begin
			n.aw_full = 1'b1;
			n.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s.w_full) begin
			n.w_full = 1'b1;
			n.w_data = s_axi_wdata;
			n.w_strb = s_axi_wstrb;
		end
		if (s.bvalid && s_axi_bready) begin
			n.bvalid = 1'b0;
		end
		if (s.aw_full && s.w_full && !s.bvalid) begin
			n.aw_full = 1'b0;
			n.w_full = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = known_index(wr_idx) ? RESP_OKAY : RESP_SLVERR;
			if (s.w_strb[0]) begin
				case (wr_idx)
					IDX_VS_CTRL: n.vs_ctrl = s.w_data[7:0]; // [R12] [R6]
					IDX_VS_DUR: n.vs_dur = s.w_data[7:0]; // [R6]
					IDX_OUT_CTRL: n.out_ctrl = s.w_data[7:0]; // [R2] [R5]
					IDX_HS_WIDTH: n.hs_width = s.w_data[7:0]; // [R2]
					IDX_SLICER: n.slicer = slicer_e'(s.w_data[1:0]); // [R8]
					default: n.bresp = n.bresp;
				endcase
			end
		end

		// ==========================================
		// Register read
		rd_val = '0;
		case (rd_idx)
			IDX_VS_CTRL: rd_val[7:0] = s.vs_ctrl;
			IDX_VS_DUR: rd_val[7:0] = s.vs_dur;
			IDX_OUT_CTRL: rd_val[7:0] = s.out_ctrl;
			IDX_HS_WIDTH: rd_val[7:0] = s.hs_width;
			IDX_SLICER: rd_val[1:0] = s.slicer;
			IDX_STATUS: begin
				rd_val[ST_FIELD_BIT] = s.field_odd;
				rd_val[ST_STRAP_BIT] = s.addr_strap;
				rd_val[ST_VS_LOW_BIT] = vs_active_low;
				rd_val[ST_HS_ACT_BIT] = (s.hs_cnt != 8'h00);
				rd_val[ST_RUN_BIT] = (s.phase == PH_RUN);
			end
			default: rd_val = '0;
		endcase
		if (s.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
		end
		if (s_axi_arvalid && !s.rvalid) begin
			n.rvalid = 1'b1;
			n.rdata = rd_val;
			n.rresp = known_index(rd_idx) ? RESP_OKAY : RESP_SLVERR;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= STATE_RST;
		end else begin
			s <= n;
		end
	end

	// ==========================================
	// Outputs
	assign s_axi_awready = !s.aw_full;
	assign s_axi_wready = !s.w_full;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_bresp = s.bresp;
	assign s_axi_arready = !s.rvalid;
	assign s_axi_rvalid = s.rvalid;
	assign s_axi_rdata = s.rdata;
	assign s_axi_rresp = s.rresp;
	assign line_sync_out = s.line_out;
	assign frame_sync_out = s.frame_out; // [R7]
	assign frame_sync_oe = (s.phase == PH_RUN); // [R11]
	assign slicer_select_out = s.slicer_out;
	assign field_odd = s.field_odd;
	assign address_strap_bit = s.addr_strap;
endmodule // sync_output_stage

// ### core/sync_pkg.sv
// How it works
// R1 - Line sync out regenerated, retimed to pixel clock
// R2 - Line sync polarity and width set by registers
// R3 - Line sync fixed to pixel clock edges
// R4 - Frame sync out: separated or pass-through
// R5 - One bit selects frame sync out polarity
// R6 - Frame sync width: source or programmed
// R7 - Address strap never alters frame sync output
// R8 - Slicer output picks one of four sources
// R9 - Slicer output gets selection only
// R10 - Field output reports odd or even field
// R11 - Strap pin level sampled at start-up
// R12 - Frame sync input sense auto or forced
// R13 - Field updates once per frame sync
package sync_pkg;

	// ==========================================
	// Bus widths and responses
	localparam int ADDR_W = 10;
	localparam int DATA_W = 32;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================
	// Register indices (byte address is four times the index)
	localparam logic [7:0] IDX_VS_CTRL = 8'h14;
	localparam logic [7:0] IDX_VS_DUR = 8'h15;
	localparam logic [7:0] IDX_OUT_CTRL = 8'h16;
	localparam logic [7:0] IDX_HS_WIDTH = 8'h17;
	localparam logic [7:0] IDX_STATUS = 8'h18;
	localparam logic [7:0] IDX_SLICER = 8'h1d;

	// ==========================================
	// Field positions
	localparam int VS_POL_FORCE_BIT = 5;
	localparam int VS_POL_LEVEL_BIT = 4;
	localparam int VS_DUR_EN_BIT = 3;
	localparam int OUT_HS_POL_BIT = 0;
	localparam int OUT_VS_POL_BIT = 1;
	localparam int OUT_VS_PASS_BIT = 2;
	localparam int ST_FIELD_BIT = 0;
	localparam int ST_STRAP_BIT = 1;
	localparam int ST_VS_LOW_BIT = 2;
	localparam int ST_HS_ACT_BIT = 3;
	localparam int ST_RUN_BIT = 4;

	// ==========================================
	// Reset values
	localparam logic [7:0] RST_VS_CTRL = 8'h00;
	localparam logic [7:0] RST_VS_DUR = 8'h04;
	localparam logic [7:0] RST_OUT_CTRL = 8'h03;
	localparam logic [7:0] RST_HS_WIDTH = 8'h20;
	localparam logic [1:0] RST_SLICER = 2'h0;

	// ==========================================
	// Timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int STRAP_NS = 1000;
	localparam int STRAP_CYC = (STRAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 16;
	localparam logic [CNT_W-1:0] POL_ACC_MAX = 16'h7fff;

	// ==========================================
	// Enumerations
	typedef enum logic [1:0] {
		SL_GREEN_RAW = 2'b00,
		SL_LINE_RAW = 2'b01,
		SL_LINE_REGEN = 2'b10,
		SL_LINE_FILT = 2'b11
	} slicer_e;

	typedef enum logic {
		PH_STRAP = 1'b0,
		PH_RUN = 1'b1
	} phase_e;

	// ==========================================
	// Carriers
	typedef struct packed {
		logic vs_pin;
		logic pix_clk;
		logic filt_line;
		logic regen_line;
		logic sep_frame;
		logic frame;
		logic line;
		logic green;
	} pins_s;

	localparam int PINS_W = $bits(pins_s);

	typedef struct packed {
		phase_e phase;
		logic [7:0] strap_cnt;
		logic addr_strap;
		logic [7:0] vs_ctrl;
		logic [7:0] vs_dur;
		logic [7:0] out_ctrl;
		logic [7:0] hs_width;
		slicer_e slicer;
		logic aw_full;
		logic [ADDR_W-1:0] aw_addr;
		logic w_full;
		logic [DATA_W-1:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [DATA_W-1:0] rdata;
		logic [1:0] rresp;
		logic hs_pend;
		logic [7:0] hs_cnt;
		logic [CNT_W-1:0] hcount;
		logic [CNT_W-1:0] line_len;
		logic [CNT_W-1:0] pol_acc;
		logic vs_prev;
		logic [7:0] vs_cnt;
		logic field_odd;
		logic line_out;
		logic frame_out;
		logic slicer_out;
	} state_s;

	localparam state_s STATE_RST = '{
		phase: PH_STRAP,
		strap_cnt: 8'h00,
		addr_strap: 1'b0,
		vs_ctrl: RST_VS_CTRL,
		vs_dur: RST_VS_DUR,
		out_ctrl: RST_OUT_CTRL,
		hs_width: RST_HS_WIDTH,
		slicer: SL_GREEN_RAW,
		aw_full: 1'b0,
		aw_addr: '0,
		w_full: 1'b0,
		w_data: '0,
		w_strb: 4'h0,
		bvalid: 1'b0,
		bresp: RESP_OKAY,
		rvalid: 1'b0,
		rdata: '0,
		rresp: RESP_OKAY,
		hs_pend: 1'b0,
		hs_cnt: 8'h00,
		hcount: '0,
		line_len: '0,
		pol_acc: '0,
		vs_prev: 1'b0,
		vs_cnt: 8'h00,
		field_odd: 1'b0,
		line_out: 1'b0,
		frame_out: 1'b0,
		slicer_out: 1'b0
	};

endpackage

// ### core/edge_sync.sv
`timescale 1ns/1ps
module edge_sync #(
	parameter int W = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] lvl,
	output logic [W-1:0] rise,
	output logic [W-1:0] fall
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stab;
		logic [W-1:0] prev;
	} es_s;

	es_s s;
	es_s n;

	// ==========================================
	// Two-stage synchroniser and edge finder
	always_comb begin
		n = s;
		n.meta = d;
		n.stab = s.meta;
		n.prev = s.stab;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign lvl = s.stab;
	assign rise = s.stab & ~s.prev;
	assign fall = ~s.stab & s.prev;
endmodule // edge_sync

// ### tb/sync_output_stage_properties.sv
`timescale 1ns/1ps
// ==========================================
// Port checks
module sync_output_stage_properties (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [sync_pkg::DATA_W-1:0] s_axi_rdata,
	input wire logic frame_sync_oe,
	input wire logic address_strap_bit,
	input wire logic field_odd
);
	import sync_pkg::*;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [7:0] up_r;
	// Cycles since reset release
	always_ff @(posedge aclk) begin
		up_r <= !aresetn ? 8'h00 : (up_r == 8'hff ? up_r : up_r + 8'h01);
	end
	a_aw_taken: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("awready high after take");
	a_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response late");
	a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	a_oe_late: assert property (frame_sync_oe |-> up_r >= 8'h0a)
		else $error("pin driven during strap");
	a_oe_stays: assert property (frame_sync_oe |=> frame_sync_oe)
		else $error("pin drive dropped");
	a_strap_held: assert property (frame_sync_oe |=> $stable(address_strap_bit))
		else $error("strap bit changed");
	a_field_hold: assert property ($changed(field_odd) |=> $stable(field_odd) [*8])
		else $error("field toggled too soon");
endmodule // sync_output_stage_properties

bind sync_output_stage sync_output_stage_properties u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
	.s_axi_rdata, .frame_sync_oe, .address_strap_bit, .field_odd);

// ### tb/display_rx_model.sv
`timescale 1ns/1ps
// ==========================================
// Receiver with pixel clock and strap pull
module display_rx_model (
	input wire logic run,
	input wire logic strap_level,
	input wire logic line_sync_out,
	input wire logic frame_sync_out,
	input wire logic frame_sync_oe,
	output logic pix_clk,
	output logic pin_level,
	output logic [7:0] width
);
	logic [7:0] cnt;
	initial begin
		pix_clk = 1'b0;
		cnt = 8'h00;
		width = 8'h00;
	end
	// Clock stands low when idle
	always #400 pix_clk = run ? ~pix_clk : 1'b0;
	assign pin_level = frame_sync_oe ? frame_sync_out : strap_level;
	// Line pulse length in pixel edges
	always @(posedge pix_clk) begin
		if (line_sync_out) begin
			cnt <= cnt + 8'h01;
		end else if (cnt != 8'h00) begin
			width <= cnt;
			cnt <= 8'h00;
		end
	end
endmodule // display_rx_model

// ### tb/sync_output_stage_bench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module sync_output_stage_bench;
	import sync_pkg::*;
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid, lso, fso, oe, slo, fodd, strap, pix, pin;
	logic [9:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata;
	logic [1:0] bresp, rresp;
	logic [3:0] src = 0;
	logic [7:0] lcnt = 0, width;
	logic fin = 0, sep = 0, run = 0, lines_on = 0;
	int err_count = 0, compares = 0;
	// ==========================================
	// Clock, line generator, parts
	initial forever #50 aclk = ~aclk;
	always @(posedge aclk) lcnt <= lcnt == 8'h27 ? 8'h00 : lcnt + 8'h01;
	sync_output_stage u_sync_output_stage (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .pixel_output_clock(pix),
		.line_sync_in(lines_on ? lcnt < 8'h04 : src[1]), .green_embedded_sync(src[0]),
		.frame_sync_in(fin), .separated_frame_sync(sep), .regen_line_sync(src[2]),
		.filtered_line_sync(src[3]), .frame_sync_pin_in(pin), .line_sync_out(lso), .frame_sync_out(fso),
		.frame_sync_oe(oe), .slicer_select_out(slo), .field_odd(fodd), .address_strap_bit(strap));
	display_rx_model u_display_rx_model (.run(run), .strap_level(1'b1), .line_sync_out(lso),
		.frame_sync_out(fso), .frame_sync_oe(oe), .pix_clk(pix), .pin_level(pin), .width(width));
	// ==========================================
	// Bus tasks
	task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [1:0] r);
		bit ad, dd;
		ad = 0;
		dd = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (!(ad && dd)) begin
			@(posedge aclk);
			if (awvalid && awready) begin
				ad = 1;
				awvalid <= 0;
			end
			if (wvalid && wready) begin
				dd = 1;
				wvalid <= 0;
			end
		end
		do @(posedge aclk); while (!bvalid);
		`CHK(bresp, r)
		bready <= 0;
	endtask
	task automatic rd(input logic [9:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do @(posedge aclk); while (!arready);
		arvalid <= 0;
		do @(posedge aclk); while (!rvalid);
		`CHK(rdata, d)
		`CHK(rresp, r)
		rready <= 0;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic t_regs;
		rd(10'h50, 32'h0, RESP_OKAY);
		rd(10'h54, 32'h4, RESP_OKAY);
		rd(10'h58, 32'h3, RESP_OKAY);
		rd(10'h5c, 32'h20, RESP_OKAY);
		rd(10'h74, 32'h0, RESP_OKAY);
		rd(10'h3fc, 32'h0, RESP_SLVERR);
		wr(10'h3fc, 32'h1, RESP_SLVERR);
		`CHK(strap, 1'b1)
		`CHK(oe, 1'b1)
		$display("test regs done");
	endtask
	task automatic t_slicer;
		for (int s = 0; s < 4; s++) begin
			wr(10'h74, s, RESP_OKAY);
			for (int v = 0; v < 2; v++) begin
				src <= v ? 4'h1 << s : ~(4'h1 << s);
				cyc(6);
				`CHK(slo, v[0])
			end
		end
		src <= 0;
		$display("test slicer done");
	endtask
	task automatic t_line;
		wr(10'h5c, 32'h3, RESP_OKAY);
		run <= 1;
		cyc(60);
		src <= 4'h2;
		cyc(10);
		src <= 0;
		cyc(50);
		`CHK(width, 8'h03)
		wr(10'h58, 32'h2, RESP_OKAY);
		cyc(16);
		`CHK(lso, 1'b1)
		wr(10'h58, 32'h3, RESP_OKAY);
		$display("test line done");
	endtask
	task automatic t_frame;
		wr(10'h50, 32'h30, RESP_OKAY);
		wr(10'h58, 32'h7, RESP_OKAY);
		fin <= 1;
		cyc(8);
		`CHK(fso, 1'b1)
		`CHK(pin, 1'b1)
		fin <= 0;
		cyc(8);
		`CHK(fso, 1'b0)
		wr(10'h58, 32'h5, RESP_OKAY);
		cyc(8);
		`CHK(fso, 1'b1)
		wr(10'h58, 32'h3, RESP_OKAY);
		sep <= 1;
		cyc(8);
		`CHK(fso, 1'b1)
		sep <= 0;
		cyc(8);
		`CHK(fso, 1'b0)
		$display("test frame done");
	endtask
	task automatic t_dur;
		wr(10'h54, 32'h2, RESP_OKAY);
		wr(10'h50, 32'h38, RESP_OKAY);
		wr(10'h58, 32'h7, RESP_OKAY);
		lines_on <= 1;
		cyc(100);
		fin <= 1;
		cyc(6);
		fin <= 0;
		cyc(14);
		`CHK(fso, 1'b1)
		cyc(130);
		`CHK(fso, 1'b0)
		$display("test duration done");
	endtask
	task automatic t_field(input int ofs, input logic exp);
		do @(posedge aclk); while (lcnt != 8'h00);
		cyc(ofs);
		fin <= 1;
		cyc(10);
		fin <= 0;
		cyc(6);
		`CHK(fodd, exp)
		cyc(30);
		`CHK(fodd, exp)
		$display("test field done");
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		#2000000;
		err_count++;
		end_sim;
	end
	initial begin
		cyc(16);
		aresetn <= 1;
		t_regs;
		t_slicer;
		t_line;
		t_frame;
		t_dur;
		wr(10'h50, 32'h30, RESP_OKAY);
		t_field(28, 1'b1);
		t_field(12, 1'b0);
		end_sim;
	end
endmodule // sync_output_stage_bench
